// ===== bench/tb_top.sv
// Testbench for the timer control block: register access sequences with expected values
`timescale 1ns/10ps
module tb_top;
	// ==================================================
	// Signals
	logic clk; // 100 MHz clock
	logic rst; // Synchronous reset
	tcc_pkg::tcc_bus_t bus; // Register request
	logic [7:0] rdata; // Read data
	logic debugHalt; // Debug halt level
	logic [1:0] captureEvent; // Capture inputs, idle
	logic [1:0] waveOut; // Waveform outputs
	logic [1:0] captureMode; // Capture enables
	logic [7:0] count; // Narrow counter keeps wraps short
	logic running; // Counter running
	logic syncBusy; // Crossing in progress
	int errors; // Mismatch count
	int total_checks; // Comparison count
	logic [7:0] d; // Read scratch
	logic [7:0] c1; // Count sample
	// ==================================================
	// Device under test
	tcc_timer_ctrl #(.CNT_WIDTH(8), .PRESCALE(4), .SYNC_DELAY(2)) u_dut (
		.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .debugHalt(debugHalt),
		.captureEvent(captureEvent), .waveOut(waveOut), .captureMode(captureMode),
		.count(count), .running(running), .syncBusy(syncBusy));
	// Clock generator
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==================================================
	// Tasks
	// Compare seen against expected
	task check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Wait whole cycles
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Print counts and the verdict, then stop
	task give_verdict();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// One-cycle write strobe
	task wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge clk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	// One-cycle read strobe, data taken in the following cycle
	task rd(input logic [4:0] a);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 d = rdata;
	endtask
	// Read and compare
	task rdc(input logic [4:0] a, input logic [7:0] e);
		rd(a);
		check({8'h00, d}, {8'h00, e});
	endtask
	// Bounded wait for the crossing to finish
	task idle();
		int i;
		i = 0;
		#1;
		while (syncBusy !== 1'b0 && i < 20) begin
			@(posedge clk);
			#1 i++;
		end
		if (i >= 20) begin
			errors++;
			give_verdict();
		end
	endtask
	// Synchronized write: busy shows, then clears
	task swr(input logic [4:0] a, input logic [7:0] v);
		wr(a, v);
		#1 check({15'h0, syncBusy}, 16'h0001);
		idle();
	endtask
	// ==================================================
	// Main sequence
	initial begin
		bus = '0;
		debugHalt = 1'b0;
		captureEvent = 2'b00;
		errors = 0;
		total_checks = 0;
		rst = 1'b1;
		cyc(2);
		rst <= 1'b0;
		// Reset values
		rdc(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h00);
		rdc(tcc_pkg::OFS_CHAN_CTRL, 8'h00);
		rdc(tcc_pkg::OFS_DEBUG_CTRL, 8'h00);
		rdc(tcc_pkg::OFS_EVENT_LO, 8'h00);
		rdc(tcc_pkg::OFS_EVENT_HI, 8'h00);
		// Set view sets, zeros keep, both views agree
		swr(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h05);
		rdc(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h05);
		rdc(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_CLR, 8'h05);
		swr(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h00);
		rdc(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h05);
		check({15'h0, running}, 16'h0000);
		swr(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_CLR, 8'h01);
		rdc(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h04);
		swr(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_CLR, 8'h04);
		rdc(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h00);
		// Enable, then retrigger counting up
		wr(tcc_pkg::OFS_ENABLE_CTRL, 8'h02);
		cyc(3);
		idle();
		swr(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h40);
		cyc(6);
		check({15'h0, running}, 16'h0001);
		rdc(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h00);
		c1 = count;
		cyc(12);
		check({15'h0, count > c1}, 16'h0001);
		// Count down
		swr(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h01);
		cyc(4);
		c1 = count;
		cyc(12);
		check({15'h0, count < c1}, 16'h0001);
		// Debug halt freezes count unless run-in-debug set
		debugHalt <= 1'b1;
		cyc(6);
		c1 = count;
		cyc(16);
		check({8'h00, count}, {8'h00, c1});
		// Debug-run is set here while the timer is disabled
		wr(tcc_pkg::OFS_ENABLE_CTRL, 8'h00);
		wr(tcc_pkg::OFS_DEBUG_CTRL, 8'h01);
		wr(tcc_pkg::OFS_ENABLE_CTRL, 8'h02);
		cyc(3);
		swr(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h40);
		cyc(6);
		c1 = count;
		cyc(16);
		check({15'h0, count != c1}, 16'h0001);
		debugHalt <= 1'b0;
		// Continuous mode survives one wrap
		cyc(1100);
		check({15'h0, running}, 16'h0001);
		// Stop, then reserved code leaves it stopped
		swr(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h80);
		cyc(6);
		check({15'h0, running}, 16'h0000);
		swr(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'hC0);
		cyc(6);
		check({15'h0, running}, 16'h0000);
		// Single-run up: wraps once then stops at zero
		swr(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_CLR, 8'hC1);
		swr(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h44);
		cyc(6);
		check({15'h0, running}, 16'h0001);
		begin : wait_stop
			int i;
			for (i = 0; i < 1500 && running === 1'b1; i++) cyc(1);
		end
		check({15'h0, running}, 16'h0000);
		check({8'h00, count}, 16'h0000);
		// Event control refused while enabled
		wr(tcc_pkg::OFS_EVENT_LO, 8'h5A);
		rdc(tcc_pkg::OFS_EVENT_LO, 8'h00);
		// Software reset keeps debug control and clears control-B
		wr(tcc_pkg::OFS_ENABLE_CTRL, 8'h01);
		cyc(4);
		idle();
		rdc(tcc_pkg::OFS_DEBUG_CTRL, 8'h01);
		rdc(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h00);
		// Disabled: event control accepts both bytes
		wr(tcc_pkg::OFS_EVENT_LO, 8'h5A);
		wr(tcc_pkg::OFS_EVENT_HI, 8'hA5);
		rdc(tcc_pkg::OFS_EVENT_LO, 8'h5A);
		rdc(tcc_pkg::OFS_EVENT_HI, 8'hA5);
		// Channel capture select and output inversion
		swr(tcc_pkg::OFS_CHAN_CTRL, 8'h33);
		cyc(2);
		check({14'h0, captureMode}, 16'h0003);
		check({14'h0, waveOut}, 16'h0003);
		swr(tcc_pkg::OFS_CHAN_CTRL, 8'h10);
		cyc(2);
		check({14'h0, captureMode}, 16'h0001);
		check({14'h0, waveOut}, 16'h0000);
		// Write protection drops control writes
		wr(tcc_pkg::OFS_PROTECT, 8'h01);
		wr(tcc_pkg::OFS_CHAN_CTRL, 8'h22);
		cyc(4);
		rdc(tcc_pkg::OFS_CHAN_CTRL, 8'h10);
		wr(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h01);
		cyc(4);
		rdc(tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET, 8'h00);
		wr(tcc_pkg::OFS_PROTECT, 8'h00);
		swr(tcc_pkg::OFS_CHAN_CTRL, 8'h22);
		rdc(tcc_pkg::OFS_CHAN_CTRL, 8'h22);
		give_verdict();
	end
endmodule // tb_top

// ===== rtl/tcc_pkg.sv
// Package: register map, field positions, reset values and types for the timer control block
package tcc_pkg;
	// ==================================================
	// Register offsets
	localparam logic [4:0] OFS_SHARED_CONTROL_B_STATE_CLR = 5'h04;
	localparam logic [4:0] OFS_SHARED_CONTROL_B_STATE_SET = 5'h05;
	localparam logic [4:0] OFS_CHAN_CTRL = 5'h06;
	localparam logic [4:0] OFS_DEBUG_CTRL = 5'h08;
	localparam logic [4:0] OFS_EVENT_LO = 5'h0A;
	localparam logic [4:0] OFS_EVENT_HI = 5'h0B;
	localparam logic [4:0] OFS_ENABLE_CTRL = 5'h10;
	localparam logic [4:0] OFS_STATUS = 5'h11;
	localparam logic [4:0] OFS_PROTECT = 5'h12;
	// ==================================================
	// Field positions
	localparam int BIT_DIR = 0;
	localparam int BIT_SINGLE = 2;
	localparam int BIT_CMD_LO = 6;
	localparam int BIT_CAPT0 = 4;
	localparam int BIT_INV0 = 0;
	localparam int BIT_RUN_WHILE_DEBUG_HALTED = 0;
	localparam int BIT_ENABLE = 1;
	localparam int BIT_SWRESET = 0;
	// ==================================================
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_EVENT = 16'h0000;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] MAX_COUNT = 16'hFFFF;
	// Command encodings
	typedef enum logic [1:0] {
		CMD_NONE = 2'h0,
		CMD_RETRIGGER = 2'h1,
		CMD_STOP = 2'h2,
		CMD_RESERVED = 2'h3
	} tcc_cmd_t;
	// Register bus request
	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tcc_bus_t;
	// Shared control-B state
	typedef struct packed {
		logic [1:0] cmd;
		logic single;
		logic down;
	} tcc_shared_control_b_state_t;
endpackage

// ===== rtl/tcc_timer_ctrl.sv
// Timer control: control-B set/clear views, channel control, debug control, event control, small counter
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
// How it works
// - Set view writes ones into control-B
// - Set and clear views share one state
// - Command runs on next prescaled tick
// - Executed command reads back as zero, unless a set-view command applies in the same cycle
// - Zero command write changes nothing
// - One retriggers, two stops, three reserved
// - Set-view one makes command pending
// - Set-view one enables single-run
// - Single-run stops after next wrap
// - Set-view zeros leave bits unchanged
// - Set-view direction one counts down
// - Direction zero up, one down
// - Capture-enable selects capture or compare
// - Inversion bit inverts waveform output
// - Debug halt stops counter unless run
// - Debug-run survives software reset
// - Synchronized, write-protected control registers
// - Event control writable only when disabled
// - Clear-view one cancels pending command
// - Clear-view direction one counts up
module tcc_timer_ctrl #(
	parameter int CNT_WIDTH = 16,
	parameter int PRESCALE = 4,
	parameter int SYNC_DELAY = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire tcc_pkg::tcc_bus_t bus,
	output logic [7:0] rdata,
	input wire logic debugHalt,
	input wire logic [1:0] captureEvent,
	output logic [1:0] waveOut,
	output logic [1:0] captureMode,
	output logic [CNT_WIDTH-1:0] count,
	output logic running,
	output logic syncBusy
);
	// ==================================================
	// Bus decode
	logic wrEn;
	logic protectOn;
	logic enable;
	logic swReset;
	tcc_pkg::tcc_shared_control_b_state_t shared_control_b_state;
	logic [1:0] captEn;
	logic [1:0] invEn;
	logic run_while_debug_halted;
	logic [15:0] event_control;
	logic [7:0] pendData;
	logic [4:0] pendAddr;
	logic [3:0] syncCnt;
	logic tick;
	logic [7:0] preCnt;
	logic cmdDone;
	logic wrapped;
	logic [CNT_WIDTH-1:0] cc0;
	logic [CNT_WIDTH-1:0] cc1;
	logic [1:0] waveRaw;
	logic [1:0] debugSync1;
	logic debugSync2;
	logic [1:0] captSync1;
	logic [1:0] captSync2;
	logic [1:0] captPrev;
	logic counterActive;

	// Write protection gates all register writes except those to the protection register
	assign wrEn = bus.wr && !protectOn;

	// ==================================================
	// Input synchronisers (debug halt and capture pins)
	always_ff @(posedge clk) begin
		if (rst) begin
			debugSync1 <= 2'h0;
			captSync1 <= 2'h0;
			debugSync2 <= 1'b0;
			captSync2 <= 2'h0;
		end else begin
			debugSync1 <= {1'b0, debugHalt};
			captSync1 <= captureEvent;
			debugSync2 <= debugSync1[0];
			captSync2 <= captSync1;
		end
	end

	// ==================================================
	// Protection register: once set, blocks writes until a write of zero or reset
	always_ff @(posedge clk) begin
		if (rst) begin
			protectOn <= 1'b0;
		end else if (bus.wr && bus.addr == tcc_pkg::OFS_PROTECT) begin
			protectOn <= bus.wdata[0];
		end
	end

	// ==================================================
	// Enable and software reset
	always_ff @(posedge clk) begin
		if (rst || swReset) begin
			enable <= 1'b0;
		end else if (wrEn && bus.addr == tcc_pkg::OFS_ENABLE_CTRL) begin
			enable <= bus.wdata[tcc_pkg::BIT_ENABLE];
		end
	end

	// Software reset pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			swReset <= 1'b0;
		end else begin
			swReset <= wrEn && bus.addr == tcc_pkg::OFS_ENABLE_CTRL && bus.wdata[tcc_pkg::BIT_SWRESET];
		end
	end

	// ==================================================
	// Debug control: software reset leaves it alone
	always_ff @(posedge clk) begin
		if (rst) begin
			run_while_debug_halted <= 1'b0;
		end else if (wrEn && bus.addr == tcc_pkg::OFS_DEBUG_CTRL) begin
			run_while_debug_halted <= bus.wdata[tcc_pkg::BIT_RUN_WHILE_DEBUG_HALTED];
		end
	end

	// ==================================================
	// Event control: writes refused while enabled
	always_ff @(posedge clk) begin
		if (rst || swReset) begin
			event_control <= tcc_pkg::RST_EVENT;
		end else if (wrEn && !enable && bus.addr == tcc_pkg::OFS_EVENT_LO) begin
			event_control[7:0] <= bus.wdata;
		end else if (wrEn && !enable && bus.addr == tcc_pkg::OFS_EVENT_HI) begin
			event_control[15:8] <= bus.wdata;
		end
	end

	// ==================================================
	// Synchronised writes: held then applied after a delay
	always_ff @(posedge clk) begin
		if (rst || swReset) begin
			syncCnt <= 4'h0;
			pendAddr <= 5'h00;
			pendData <= tcc_pkg::RST_BYTE;
		end else if (syncCnt != 4'h0) begin
			syncCnt <= syncCnt - 4'h1;
		end else if (wrEn && (bus.addr == tcc_pkg::OFS_SHARED_CONTROL_B_STATE_CLR || bus.addr == tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET
			|| bus.addr == tcc_pkg::OFS_CHAN_CTRL)) begin
			syncCnt <= 4'(SYNC_DELAY);
			pendAddr <= bus.addr;
			pendData <= bus.wdata;
		end
	end
	assign syncBusy = syncCnt != 4'h0;

	// Apply strobe when the crossing delay runs out
	logic applyNow;
	assign applyNow = syncCnt == 4'h1;

	// ==================================================
	// Shared control-B state
	always_ff @(posedge clk) begin
		if (rst || swReset) begin
			shared_control_b_state <= '0;
		end else begin
			if (applyNow && pendAddr == tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET) begin
				// Set view ORs ones in; zeros keep bits
				shared_control_b_state.down <= shared_control_b_state.down | pendData[tcc_pkg::BIT_DIR];
				shared_control_b_state.single <= shared_control_b_state.single | pendData[tcc_pkg::BIT_SINGLE];
				if (pendData[7:6] != 2'h0) begin
					shared_control_b_state.cmd <= shared_control_b_state.cmd | pendData[7:6];
				end else if (cmdDone) begin
					// No new command: the executed one still retires
					shared_control_b_state.cmd <= 2'h0;
				end
			end else if (applyNow && pendAddr == tcc_pkg::OFS_SHARED_CONTROL_B_STATE_CLR) begin
				shared_control_b_state.down <= shared_control_b_state.down & ~pendData[tcc_pkg::BIT_DIR];
				shared_control_b_state.single <= shared_control_b_state.single & ~pendData[tcc_pkg::BIT_SINGLE];
				if (pendData[7:6] != 2'h0) begin
					shared_control_b_state.cmd <= 2'h0;
				end else if (cmdDone) begin
					// Executed command retires even under a clear-view write
					shared_control_b_state.cmd <= 2'h0;
				end
			end else if (cmdDone) begin
				shared_control_b_state.cmd <= 2'h0;
			end
			if (wrapped && shared_control_b_state.single) begin
				shared_control_b_state.single <= shared_control_b_state.single;
			end
		end
	end

	// ==================================================
	// Channel control
	always_ff @(posedge clk) begin
		if (rst || swReset) begin
			captEn <= 2'h0;
			invEn <= 2'h0;
		end else if (applyNow && pendAddr == tcc_pkg::OFS_CHAN_CTRL) begin
			captEn <= pendData[tcc_pkg::BIT_CAPT0 +: 2];
			invEn <= pendData[tcc_pkg::BIT_INV0 +: 2];
		end
	end

	// ==================================================
	// Prescaler: one-cycle tick pulse, stalled while disabled or during debug halt unless run-while-debug is set
	assign counterActive = enable && (run_while_debug_halted || !debugSync2);
	always_ff @(posedge clk) begin
		if (rst || swReset) begin
			preCnt <= 8'h00;
			tick <= 1'b0;
		end else if (!counterActive) begin
			tick <= 1'b0;
		end else if (preCnt == 8'(PRESCALE - 1)) begin
			preCnt <= 8'h00;
			tick <= 1'b1;
		end else begin
			preCnt <= preCnt + 8'h01;
			tick <= 1'b0;
		end
	end

	// Command retires on the prescaled tick
	assign cmdDone = tick && shared_control_b_state.cmd != 2'h0;

	// Wrap detection on the current count and direction
	assign wrapped = tick && running &&
		(shared_control_b_state.down ? count == tcc_pkg::RST_COUNT[CNT_WIDTH-1:0] : count == tcc_pkg::MAX_COUNT[CNT_WIDTH-1:0]);

	// ==================================================
	// Counter
	always_ff @(posedge clk) begin
		if (rst || swReset) begin
			count <= tcc_pkg::RST_COUNT[CNT_WIDTH-1:0];
			running <= 1'b0;
		end else if (!enable) begin
			running <= 1'b0;
		end else if (tick) begin
			if (shared_control_b_state.cmd == tcc_pkg::CMD_RETRIGGER) begin
				running <= 1'b1;
				count <= shared_control_b_state.down ? tcc_pkg::MAX_COUNT[CNT_WIDTH-1:0] : tcc_pkg::RST_COUNT[CNT_WIDTH-1:0];
			end else if (shared_control_b_state.cmd == tcc_pkg::CMD_STOP) begin
				running <= 1'b0;
			end else if (running) begin
				count <= shared_control_b_state.down ? count - 1'b1 : count + 1'b1;
				if (wrapped && shared_control_b_state.single) begin
					running <= 1'b0;
				end
			end
		end
	end

	// Registered copy of enable, read back in the status register
	logic enablePrev;
	always_ff @(posedge clk) begin
		if (rst) begin
			enablePrev <= 1'b0;
		end else begin
			enablePrev <= enable;
		end
	end

	// ==================================================
	// Channels: capture latches count, compare drives waveform
	always_ff @(posedge clk) begin
		if (rst || swReset) begin
			cc0 <= '0;
			cc1 <= '0;
			captPrev <= 2'h0;
			waveRaw <= 2'h0;
		end else begin
			captPrev <= captSync2;
			if (captEn[0] && captSync2[0] && !captPrev[0]) begin
				cc0 <= count;
			end
			if (captEn[1] && captSync2[1] && !captPrev[1]) begin
				cc1 <= count;
			end
			if (!captEn[0] && tick && running && count == cc0) begin
				waveRaw[0] <= !waveRaw[0];
			end
			if (!captEn[1] && tick && running && count == cc1) begin
				waveRaw[1] <= !waveRaw[1];
			end
		end
	end

	// Output inversion per channel
	always_ff @(posedge clk) begin
		if (rst) begin
			waveOut <= 2'h0;
		end else begin
			waveOut <= waveRaw ^ invEn;
		end
	end
	assign captureMode = captEn;

	// ==================================================
	// Read data, one cycle after the read strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				tcc_pkg::OFS_SHARED_CONTROL_B_STATE_CLR, tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET: rdata <= {shared_control_b_state.cmd, 3'h0, shared_control_b_state.single, 1'b0, shared_control_b_state.down};
				tcc_pkg::OFS_CHAN_CTRL: rdata <= {2'h0, captEn, 2'h0, invEn};
				tcc_pkg::OFS_DEBUG_CTRL: rdata <= {7'h00, run_while_debug_halted};
				tcc_pkg::OFS_EVENT_LO: rdata <= event_control[7:0];
				tcc_pkg::OFS_EVENT_HI: rdata <= event_control[15:8];
				tcc_pkg::OFS_ENABLE_CTRL: rdata <= {6'h00, enable, 1'b0};
				tcc_pkg::OFS_STATUS: rdata <= {5'h00, enablePrev, syncBusy, running};
				tcc_pkg::OFS_PROTECT: rdata <= {7'h00, protectOn};
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// ==================================================
	// Assertions
	sequence setWrite_s;
		wrEn && bus.addr == tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET && syncCnt == 4'h0;
	endsequence
	busy_on_write_a: assert property (@(posedge clk) disable iff (rst) setWrite_s |=> syncBusy) else $error("busy not raised");
	busy_bounded_a: assert property (@(posedge clk) disable iff (rst) syncBusy |-> ##[1:16] !syncBusy) else $error("busy stuck");
	dir_set_a: assert property (@(posedge clk) disable iff (rst || swReset) applyNow && pendAddr == tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET && pendData[0] |=> shared_control_b_state.down) else $error("dir not set");
	dir_clear_a: assert property (@(posedge clk) disable iff (rst || swReset) applyNow && pendAddr == tcc_pkg::OFS_SHARED_CONTROL_B_STATE_CLR && pendData[0] |=> !shared_control_b_state.down) else $error("dir not cleared");
	single_keep_a: assert property (@(posedge clk) disable iff (rst || swReset) applyNow && pendAddr == tcc_pkg::OFS_SHARED_CONTROL_B_STATE_SET && shared_control_b_state.single |=> shared_control_b_state.single) else $error("single lost");
	cmd_retire_a: assert property (@(posedge clk) disable iff (rst || swReset) cmdDone && !applyNow |=> shared_control_b_state.cmd == 2'h0) else $error("cmd not cleared");
	debug_halt_a: assert property (@(posedge clk) disable iff (rst) debugSync2 && !run_while_debug_halted |=> !tick) else $error("tick in debug halt");
	event_lock_a: assert property (@(posedge clk) disable iff (rst || swReset) enable && $past(enable) |-> $stable(event_control)) else $error("event changed while enabled");
	invert_out_a: assert property (@(posedge clk) disable iff (rst) 1'b1 |=> waveOut == ($past(waveRaw) ^ $past(invEn))) else $error("inversion wrong");
	single_run_bit_stop_a: assert property (@(posedge clk) disable iff (rst || swReset) wrapped && shared_control_b_state.single && shared_control_b_state.cmd == 2'h0 |=> !running) else $error("single run kept going");
endmodule // tcc_timer_ctrl
